// ==== pkg/twp_defs.svh ====
/*
  Constants of the timer, watchdog and prescaler block: register indices,
  field positions, reset values and status bit positions.
  Assumes it is included by bare name and holds definitions only.
*/
`ifndef TWP_DEFS_SVH
`define TWP_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TWP_IDX_TICK_COUNT   6'h01
`define TWP_IDX_TICK_CTRL    6'h07
`define TWP_IDX_WDT_CTRL     6'h08
`define TWP_IDX_PAIR_CTRL    6'h09
`define TWP_IDX_PWT_CTRL     6'h0A
`define TWP_IDX_PRESET_BASE  6'h0B
`define TWP_IDX_PRESET_LAST  6'h0E
`define TWP_IDX_STATUS       6'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TWP_NIB_SRC          3
`define TWP_TICK_SRC_BIT     5
`define TWP_TICK_EDGE_BIT    4
`define TWP_TICK_PSEN_BIT    3
`define TWP_WDT_EN_BIT       3
`define TWP_STS_TICK_OVF     4
`define TWP_STS_WDT_TMO      5

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define TWP_TICK_CTRL_RST    8'hBF
`define TWP_TICK_CTRL_MASK   8'hBF
`define TWP_WDT_CTRL_RST     8'h00
`define TWP_WDT_CTRL_MASK    8'h0F
`define TWP_CTRL_RST         8'h00
`define TWP_AXI_OKAY         2'h0
`define TWP_AXI_SLVERR       2'h2

`endif

// ==== pkg/twp_pkg.sv ====
/*
  Types of the timer, watchdog and prescaler block.
  Assumes twp_defs.svh is on the include path.
*/
`include "twp_defs.svh"

package twp_pkg;

  // Operating mode reported by the core
  typedef enum logic [1:0] {
    TWP_NORMAL,
    TWP_GREEN,
    TWP_IDLE,
    TWP_SLEEP
  } twp_mode_type;

  // Whole state of the block
  typedef struct packed {
    logic [2:0]      sync1;     // sub, main, pin: first stage
    logic [2:0]      sync2;
    logic [2:0]      sync3;     // Edge history
    logic [7:0]      pair_ctrl;
    logic [7:0]      pwt_ctrl;
    logic [7:0]      tick_ctrl;
    logic [7:0]      wdt_ctrl;
    logic [3:0][7:0] preset;
    logic [3:0][7:0] dcount;
    logic [3:0][7:0] dpre;
    logic [7:0]      tick_cnt;
    logic [7:0]      tick_pre;
    logic            wdt_half;
    logic [7:0]      wdt_pre;
    logic [7:0]      wdt_cnt;
    logic [5:0]      flags;
    logic [3:0]      evt_out;
    logic            ovf_out;
    logic            rst_out;
    logic            aw_have;
    logic [5:0]      aw_idx;
    logic            w_have;
    logic [7:0]      w_data;
    logic            w_lane;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } twp_state_type;

endpackage

// ==== hdl/twp_top.sv ====
/*
  Timer block: two preset down-counters, high and low pulse width timers,
  the 8-bit tick counter and the watchdog, each behind its own prescaler,
  with an AXI4-Lite register slave.
  Assumes MCLK at 100 MHz, the oscillators and the tick pin arrive
  asynchronously and well below MCLK/4, and the instruction, clear and
  sleep strobes are one-cycle pulses on MCLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "twp_defs.svh"

module twp_top
  import twp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  // Oscillators and counter pin
  input  wire logic        SUB_OSC,
  input  wire logic        MAIN_OSC,
  input  wire logic        TICK_PIN,
  // Core strobes and mode
  input  wire logic        INSTR_TICK,
  input  wire logic        WDT_CLEAR_INSTR,
  input  wire logic        SLEEP_INSTR,
  input  wire logic [1:0]  OP_MODE,
  // Timer events
  output var  logic [3:0]  COUNTER_EVENT,
  output var  logic        TICK_OVERFLOW,
  output var  logic        WDT_RESET,
  // AXI4-Lite write
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  output var  logic [1:0]  BRESP,
  // AXI4-Lite read
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  input  wire logic [7:0]  ARADDR,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Last prescaler count for divide by 2 ** (code + 1)
  function automatic logic [7:0] div_last(input logic [2:0] code);
    div_last = 8'((9'h002 << code) - 9'h001);
  endfunction

  // Last prescaler count for divide by 2 ** code
  function automatic logic [7:0] wdt_last(input logic [2:0] code);
    wdt_last = 8'((9'h001 << code) - 9'h001);
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == `TWP_IDX_TICK_COUNT) || (idx == `TWP_IDX_TICK_CTRL) ||
             (idx == `TWP_IDX_WDT_CTRL) || (idx == `TWP_IDX_PAIR_CTRL) ||
             (idx == `TWP_IDX_PWT_CTRL) || (idx == `TWP_IDX_STATUS) ||
             ((idx >= `TWP_IDX_PRESET_BASE) &&
              (idx <= `TWP_IDX_PRESET_LAST));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  twp_state_type r_reg;
  twp_state_type r_next;

  logic       sub_tick;
  logic       main_tick;
  logic       pin_edge;
  logic       tick_src;
  logic       tick_inc;
  logic       tick_wr;
  logic       wdt_tmo;
  logic       do_wr;
  logic [3:0] dtick;
  logic [3:0] dwrap;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [3:0] nib;
  logic [5:0] ridx;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // One process; CLK_EN low holds every bit
  always_comb begin
    r_next   = r_reg;
    nib      = 4'h0;
    ridx     = ARADDR[7:2];
    dtick    = 4'h0;
    dwrap    = 4'h0;
    flag_set = 6'h00;
    flag_clr = 6'h00;
    do_wr    = 1'b0;
    tick_wr  = 1'b0;
    tick_src = 1'b0;
    tick_inc = 1'b0;
    wdt_tmo  = 1'b0;
    // Edges from the second and third sync stages only; sub and main rising, pin rising or falling by the edge bit
    sub_tick  = r_reg.sync2[0] & ~r_reg.sync3[0];
    main_tick = r_reg.sync2[1] & ~r_reg.sync3[1];
    pin_edge  = r_reg.tick_ctrl[`TWP_TICK_EDGE_BIT] ?
                (~r_reg.sync2[2] & r_reg.sync3[2]) :
                (r_reg.sync2[2] & ~r_reg.sync3[2]);
    if (CLK_EN) begin
      r_next.sync1   = {TICK_PIN, MAIN_OSC, SUB_OSC};
      r_next.sync2   = r_reg.sync1;
      r_next.sync3   = r_reg.sync2;
      r_next.evt_out = 4'h0;
      r_next.ovf_out = 1'b0;
      r_next.rst_out = 1'b0;

      // Preset down-counters: 0 first, 1 second, 2 high, 3 low
      for (int i = 0; i < 4; i++) begin
        if (i < 2) begin
          nib = r_reg.pair_ctrl[i*4 +: 4];
        end else begin
          nib = r_reg.pwt_ctrl[(i-2)*4 +: 4];
        end
        // Bit 3 of the nibble picks main over sub
        if (nib[`TWP_NIB_SRC] ? main_tick : sub_tick) begin
          // >= keeps a shrunk ratio from running to 255 first
          if (r_reg.dpre[i] >= div_last(nib[2:0])) begin
            r_next.dpre[i] = 8'h00;
            dtick[i] = 1'b1;
          end else begin
            r_next.dpre[i] = r_reg.dpre[i] + 8'h01;
          end
        end
        dwrap[i] = dtick[i] && (r_reg.dcount[i] == 8'h00);
        if (dtick[i]) begin
          r_next.dcount[i] = dwrap[i] ? r_reg.preset[i] :
                             r_reg.dcount[i] - 8'h01;
        end
      end
      r_next.evt_out = dwrap;
      flag_set[3:0]  = dwrap;

      // Tick counter and its own prescaler
      tick_src = r_reg.tick_ctrl[`TWP_TICK_SRC_BIT] ? pin_edge :
                 INSTR_TICK;
      if (tick_src) begin
        if (!r_reg.tick_ctrl[`TWP_TICK_PSEN_BIT]) begin
          tick_inc = 1'b1;
        end else if (r_reg.tick_pre >= div_last(r_reg.tick_ctrl[2:0])) begin
          r_next.tick_pre = 8'h00;
          tick_inc = 1'b1;
        end else begin
          r_next.tick_pre = r_reg.tick_pre + 8'h01;
        end
      end
      if (tick_inc) begin
        r_next.tick_cnt = r_reg.tick_cnt + 8'h01;
        if (r_reg.tick_cnt == 8'hFF) begin
          r_next.ovf_out = 1'b1;
          flag_set[`TWP_STS_TICK_OVF] = 1'b1;
        end
      end

      // Watchdog: free running on half the sub-oscillator rate
      if (sub_tick) begin
        r_next.wdt_half = ~r_reg.wdt_half;
        if (r_reg.wdt_half) begin
          if (r_reg.wdt_pre >= wdt_last(r_reg.wdt_ctrl[2:0])) begin
            r_next.wdt_pre = 8'h00;
            r_next.wdt_cnt = r_reg.wdt_cnt + 8'h01;
            wdt_tmo = (r_reg.wdt_cnt == 8'hFF);
          end else begin
            r_next.wdt_pre = r_reg.wdt_pre + 8'h01;
          end
        end
      end
      // Reset only while enabled and not asleep
      if (wdt_tmo && r_reg.wdt_ctrl[`TWP_WDT_EN_BIT] &&
          (twp_mode_type'(OP_MODE) != TWP_SLEEP)) begin
        r_next.rst_out = 1'b1;
        flag_set[`TWP_STS_WDT_TMO] = 1'b1;
      end
      if (WDT_CLEAR_INSTR || SLEEP_INSTR) begin
        r_next.wdt_half = 1'b0;
        r_next.wdt_pre  = 8'h00;
        r_next.wdt_cnt  = 8'h00;
      end

      // AXI write: address and data taken in either order
      if (AWVALID && r_reg.awready) begin
        r_next.aw_have = 1'b1;
        r_next.aw_idx  = AWADDR[7:2];
      end
      if (WVALID && r_reg.wready) begin
        r_next.w_have = 1'b1;
        r_next.w_data = WDATA[7:0];
        r_next.w_lane = WSTRB[0];
      end
      if (r_reg.bvalid && BREADY) begin
        r_next.bvalid = 1'b0;
      end
      do_wr = r_next.aw_have && r_next.w_have && !r_reg.bvalid;
      if (do_wr) begin
        r_next.aw_have = 1'b0;
        r_next.w_have  = 1'b0;
        r_next.bvalid  = 1'b1;
        r_next.bresp   = mapped(r_next.aw_idx) ? `TWP_AXI_OKAY :
                         `TWP_AXI_SLVERR;
        if (r_next.w_lane) begin
          unique case (r_next.aw_idx)
            `TWP_IDX_TICK_COUNT: begin
              tick_wr = 1'b1;
              r_next.tick_cnt = r_next.w_data;
              r_next.tick_pre = 8'h00;
            end
            `TWP_IDX_TICK_CTRL: begin
              r_next.tick_ctrl = r_next.w_data & `TWP_TICK_CTRL_MASK;
            end
            `TWP_IDX_WDT_CTRL: begin
              r_next.wdt_ctrl = r_next.w_data & `TWP_WDT_CTRL_MASK;
            end
            `TWP_IDX_PAIR_CTRL: begin
              r_next.pair_ctrl = r_next.w_data;
            end
            `TWP_IDX_PWT_CTRL: begin
              r_next.pwt_ctrl = r_next.w_data;
            end
            `TWP_IDX_STATUS: begin
              flag_clr = r_next.w_data[5:0];
            end
            default: begin
              // A preset write also restarts that counter
              for (int i = 0; i < 4; i++) begin
                if (r_next.aw_idx == 6'(`TWP_IDX_PRESET_BASE + i)) begin
                  r_next.preset[i] = r_next.w_data;
                  r_next.dcount[i] = r_next.w_data;
                  r_next.dpre[i]   = 8'h00;
                end
              end
            end
          endcase
        end
      end
      r_next.awready = !r_next.aw_have && !r_next.bvalid;
      r_next.wready  = !r_next.w_have && !r_next.bvalid;

      // Sticky events: a set in the clearing cycle survives
      r_next.flags = (r_reg.flags & ~flag_clr) | flag_set;

      // AXI read: one outstanding, data in low byte
      if (r_reg.rvalid && RREADY) begin
        r_next.rvalid  = 1'b0;
        r_next.arready = 1'b1;
      end
      if (ARVALID && r_reg.arready) begin
        r_next.rvalid  = 1'b1;
        r_next.arready = 1'b0;
        r_next.rresp   = mapped(ridx) ? `TWP_AXI_OKAY : `TWP_AXI_SLVERR;
        r_next.rdata   = 32'h0000_0000;
        unique case (ridx)
          `TWP_IDX_TICK_COUNT: r_next.rdata[7:0] = r_reg.tick_cnt;
          `TWP_IDX_TICK_CTRL:  r_next.rdata[7:0] = r_reg.tick_ctrl;
          `TWP_IDX_WDT_CTRL:   r_next.rdata[7:0] = r_reg.wdt_ctrl;
          `TWP_IDX_PAIR_CTRL:  r_next.rdata[7:0] = r_reg.pair_ctrl;
          `TWP_IDX_PWT_CTRL:   r_next.rdata[7:0] = r_reg.pwt_ctrl;
          `TWP_IDX_STATUS:     r_next.rdata[5:0] = r_reg.flags;
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (ridx == 6'(`TWP_IDX_PRESET_BASE + i)) begin
                r_next.rdata[7:0] = r_reg.preset[i];
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Constants only under reset; watchdog starts disabled
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_reg           <= '0;
      r_reg.tick_ctrl <= `TWP_TICK_CTRL_RST;
      r_reg.wdt_ctrl  <= `TWP_WDT_CTRL_RST;
      r_reg.pair_ctrl <= `TWP_CTRL_RST;
      r_reg.pwt_ctrl  <= `TWP_CTRL_RST;
      r_reg.arready   <= 1'b1;
      r_reg.awready   <= 1'b1;
      r_reg.wready    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flops
  assign COUNTER_EVENT = r_reg.evt_out;
  assign TICK_OVERFLOW = r_reg.ovf_out;
  assign WDT_RESET     = r_reg.rst_out;
  assign AWREADY       = r_reg.awready;
  assign WREADY        = r_reg.wready;
  assign BVALID        = r_reg.bvalid;
  assign BRESP         = r_reg.bresp;
  assign ARREADY       = r_reg.arready;
  assign RVALID        = r_reg.rvalid;
  assign RDATA         = r_reg.rdata;
  assign RRESP         = r_reg.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  chk_tick_wr_clear: assert property (
    CLK_EN && tick_wr |=> r_reg.tick_pre == 8'h00)
    else $error("tick prescaler not cleared by counter write");

  chk_wdt_clear: assert property (
    CLK_EN && (WDT_CLEAR_INSTR || SLEEP_INSTR)
    |=> r_reg.wdt_pre == 8'h00 && r_reg.wdt_cnt == 8'h00)
    else $error("watchdog prescaler not cleared");

  chk_wdt_reset: assert property (
    CLK_EN && wdt_tmo && r_reg.wdt_ctrl[`TWP_WDT_EN_BIT] &&
    (OP_MODE != 2'h3) |=> WDT_RESET ##1 !WDT_RESET || !CLK_EN)
    else $error("watchdog timeout did not reset once");

  chk_wdt_enable: assert property (
    WDT_RESET |-> $past(r_reg.wdt_ctrl[`TWP_WDT_EN_BIT]) &&
    $past(wdt_tmo))
    else $error("watchdog reset without enable and timeout");

  chk_dcnt_reload: assert property (
    CLK_EN && dwrap[0] && !do_wr
    |=> r_reg.dcount[0] == $past(r_reg.preset[0]) && COUNTER_EVENT[0])
    else $error("first counter did not reload with event");

  chk_dcnt_step: assert property (
    CLK_EN && dtick[1] && !dwrap[1] && !do_wr
    |=> r_reg.dcount[1] == $past(r_reg.dcount[1]) - 8'h01)
    else $error("second counter missed a decrement");

  chk_tick_direct: assert property (
    CLK_EN && INSTR_TICK && !tick_wr &&
    r_reg.tick_ctrl[5:3] == 3'b000
    |=> r_reg.tick_cnt == $past(r_reg.tick_cnt) + 8'h01)
    else $error("tick counter missed an instruction cycle");

  chk_flag_set_wins: assert property (
    CLK_EN && flag_set[0] && flag_clr[0] |=> r_reg.flags[0])
    else $error("event lost in clearing cycle");

  cov_wdt_reset: cover property (WDT_RESET);
  cov_tick_ovf:  cover property (TICK_OVERFLOW);
  cov_low_event: cover property (COUNTER_EVENT[3] ##[1:1000] COUNTER_EVENT[3]);

endmodule
`default_nettype wire

// ==== tb/twp_far_model.sv ====
/*
  Far side of the timer block: sub and main oscillators and counter pin.
  Assumes the bench asks for pin levels through pin_want.
*/
`timescale 1ns/10ps
`default_nettype none

module twp_far_model (
  // Pin level asked for by the bench
  input  wire logic pin_want,
  // Lines into the block
  output var  logic sub_osc,
  output var  logic main_osc,
  output var  logic tick_pin
);
  // Start levels
  initial begin
    sub_osc  = 1'b0;
    main_osc = 1'b0;
    tick_pin = 1'b0;
  end
  // Free-running clocks; edges sit off the MCLK edge so sync lag is fixed
  always #40 sub_osc = ~sub_osc;
  always #30 main_osc = ~main_osc;
  // Pin follows the bench after a short board delay
  always @(pin_want) tick_pin <= #3 pin_want;
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the timer block against a shadow model.
  Assumes twp_far_model makes the oscillators and the counter pin.
*/
`timescale 1ns/10ps
`default_nettype none
`include "twp_defs.svh"

module tb_top
  import twp_pkg::*;
;
  // ----------------
  // Signals
  // ----------------
  logic        MCLK, RESET_N, INSTR_TICK, WDT_CLEAR_INSTR, SLEEP_INSTR;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, TICK_OVERFLOW;
  logic        WDT_RESET, SUB_OSC, MAIN_OSC, TICK_PIN, pin_want, CLK_EN;
  logic [1:0]  OP_MODE, BRESP, RRESP;
  logic [3:0]  COUNTER_EVENT, WSTRB;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rnd, q;
  logic [4:0]  evv;
  int          error_cnt, n_tests, sub_n, main_n, ovf_n, mdl[0:31];
  int          k, s, c, p, e0, o0, nn;
  bit          hit;

  twp_top dut (
    .MCLK(MCLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .SUB_OSC(SUB_OSC),
    .MAIN_OSC(MAIN_OSC), .TICK_PIN(TICK_PIN), .INSTR_TICK(INSTR_TICK),
    .WDT_CLEAR_INSTR(WDT_CLEAR_INSTR), .SLEEP_INSTR(SLEEP_INSTR),
    .OP_MODE(OP_MODE), .COUNTER_EVENT(COUNTER_EVENT),
    .TICK_OVERFLOW(TICK_OVERFLOW), .WDT_RESET(WDT_RESET),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

  twp_far_model far (.pin_want(pin_want), .sub_osc(SUB_OSC),
    .main_osc(MAIN_OSC), .tick_pin(TICK_PIN));

  // Clock and edge tallies; source edges are counted at the pins
  always #5 MCLK = ~MCLK;
  always @(posedge SUB_OSC) sub_n++;
  always @(posedge MAIN_OSC) main_n++;
  always @(posedge MCLK) if (TICK_OVERFLOW === 1'b1) ovf_n++;
  assign evv = {WDT_RESET, COUNTER_EVENT};

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Readable bits of each index; zero marks an unmapped place
  function automatic int rmask(input int i);
    if (i == 7) return 8'hBF;
    if (i == 8) return 8'h0F;
    if (i == 16) return 8'h3F;
    return (i == 1 || (i >= 9 && i <= 14)) ? 8'hFF : 0;
  endfunction

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input int i, input logic [7:0] d);
    int n;
    bit aw, w;
    @(posedge MCLK);
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    AWADDR  <= 8'(i * 4);
    WDATA   <= {24'h000000, d};
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w) && n < 50) begin
      @(posedge MCLK);
      n++;
      aw |= (AWREADY === 1'b1);
      w |= (WREADY === 1'b1);
      AWVALID <= !aw;
      WVALID <= !w;
    end
    while (BVALID !== 1'b1 && n < 50) begin
      @(posedge MCLK);
      n++;
    end
    BREADY <= 1'b0;
    chk("write handshake", n < 50, 1'b1);
    chk("write response", BRESP, rmask(i) ? 2'h0 : 2'h2);
    if (rmask(i) != 0) mdl[i] = d & rmask(i);
  endtask

  task automatic rd(input int i);
    int n;
    @(posedge MCLK);
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    ARADDR  <= 8'(i * 4);
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (ARREADY !== 1'b1 && n < 50);
    ARVALID <= 1'b0;
    do begin
      @(posedge MCLK);
      n++;
    end while (RVALID !== 1'b1 && n < 50);
    q = RDATA;
    RREADY <= 1'b0;
    chk("read handshake", n < 50, 1'b1);
    chk("read response", RRESP, rmask(i) ? 2'h0 : 2'h2);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge MCLK);
      INSTR_TICK <= 1'b1;
      @(posedge MCLK);
      INSTR_TICK <= 1'b0;
    end
  endtask

  // Bounded wait for a one-cycle event pulse
  task automatic wait_evt(input int b, input int lim);
    int n;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge MCLK);
      n++;
      hit = (evv[b] === 1'b1);
    end
  endtask

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    #1_000_000;
    error_cnt++;
    conclude();
  end

  initial begin
    MCLK = 1'b0;
    RESET_N = 1'b0;
    {INSTR_TICK, WDT_CLEAR_INSTR, SLEEP_INSTR, pin_want} = 4'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, OP_MODE} = 18'h00000;
    WDATA = 32'h00000000;
    WSTRB = 4'hF;
    CLK_EN = 1'b1;
    rnd = 32'h000115F9;
    mdl[7] = 8'hBF;
    repeat (6) @(posedge MCLK);
    RESET_N <= 1'b1;
    // Reset values, then random write and read back incl. unmapped places
    for (k = 0; k < 16; k++) begin
      rd(k);
      chk("reset value", q, mdl[k]);
    end
    for (k = 3; k < 15; k++) begin
      rnd = lfsr(rnd);
      wr(k, rnd[7:0]);
      rd(k);
      chk("read back", q, mdl[k]);
    end
    // A write without its low byte lane must leave the register alone
    e0 = mdl[12];
    WSTRB <= 4'h0;
    wr(12, 8'(~e0));
    WSTRB <= 4'hF;
    mdl[12] = e0;
    rd(12);
    chk("masked write", q, mdl[12]);
    // Instruction-clocked tick counter across the wrap
    wr(7, 8'h00);
    wr(1, 8'hFE);
    o0 = ovf_n;
    pulse(3);
    rd(1);
    chk("tick count", q, 32'h01);
    chk("overflow pulses", ovf_n - o0, 1);
    // Prescaled ticks; a stale prescale count would show as an early step
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      wr(7, 8'(8 + k));
      pulse(1);
      wr(1, rnd[7:0]);
      pulse((2 << k) - 1);
      rd(1);
      chk("tick held", q, rnd[7:0]);
      pulse(1);
      rd(1);
      chk("tick prescaled", q, 8'(rnd[7:0] + 1));
    end
    // Clock enable low: instruction pulses must not count, then resume
    rnd = lfsr(rnd);
    wr(7, 8'h00);
    wr(1, rnd[7:0]);
    CLK_EN <= 1'b0;
    pulse(3);
    CLK_EN <= 1'b1;
    rd(1);
    chk("tick frozen", q, rnd[7:0]);
    pulse(1);
    rd(1);
    chk("tick resumed", q, 8'(rnd[7:0] + 1));
    // Pin source; ending high makes rising and falling counts differ
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      nn = rnd[2:0] + 2;
      wr(7, 8'(8'h20 + k * 16));
      wr(1, 8'h00);
      repeat (nn) begin
        pin_want <= 1'b1;
        repeat (6) @(posedge MCLK);
        pin_want <= 1'b0;
        repeat (6) @(posedge MCLK);
      end
      pin_want <= 1'b1;
      repeat (6) @(posedge MCLK);
      rd(1);
      chk("pin edge count", q, nn + (k == 0));
      pin_want <= 1'b0;
      repeat (6) @(posedge MCLK);
    end
    // Down-counters from either oscillator, period in source edges
    for (k = 0; k < 4; k++) begin
      for (s = 0; s < 2; s++) begin
        c = (k + s) % 3;
        p = k + 2;
        wr(9 + k / 2, 8'((s * 8 + c) << (4 * (k % 2))));
        wr(11 + k, 8'(p));
        wr(16, 8'h3F);
        wait_evt(k, 1000);
        e0 = s ? main_n : sub_n;
        wait_evt(k, 1000);
        nn = (p + 1) << (c + 1);
        chk("down event", hit, 1'b1);
        chk("down period", (s ? main_n : sub_n) - e0, nn);
        rd(16);
        chk("down flag", q[k], 1'b1);
      end
    end
    // Watchdog over modes, ratios, clear and sleep strobes, disabled
    for (k = 0; k < 5; k++) begin
      c = k % 2;
      OP_MODE <= 2'(k % 4);
      wr(8, 8'((k < 4) * 8 + c));
      @(posedge SUB_OSC);
      repeat (4) @(posedge MCLK);
      WDT_CLEAR_INSTR <= !c;
      SLEEP_INSTR <= c;
      e0 = sub_n;
      @(posedge MCLK);
      {WDT_CLEAR_INSTR, SLEEP_INSTR} <= 2'h0;
      wait_evt(4, (512 << c) * 8 + 100);
      chk("watchdog fired", hit, k < 3);
      if (hit) chk("watchdog span", sub_n - e0, 512 << c);
    end
    conclude();
  end
endmodule

`default_nettype wire
